// file: src/isa_subset_exec_unit.sv
// execution unit for a subset of an 8-bit instruction set, apb slave
// assumes one apb master on pclk; program words loaded through apb
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "exec_unit_consts.svh"

// Overview of operation
// (RULE1) borrow subtract: work minus operand into memory
// (RULE2) subtraction carry: 0 negative, 1 otherwise
// (RULE3) decrement memory, skip on zero, flags kept
// (RULE4) decrement into work, memory kept, skip zero
// (RULE5) skip taken adds one dummy cycle
// (RULE6) set byte writes all ones, no flags
// (RULE7) set bit forces one bit, no flags
// (RULE8) increment memory, skip on wrap, flags kept
// (RULE9) increment into work, memory kept, skip zero
// (RULE10) skip when selected bit is set
// (RULE11) plain subtract to work or memory
// (RULE12) swap nibbles in memory, no flags
// (RULE13) swapped operand into work, memory kept
// (RULE14) skip when operand is zero
// (RULE15) copy operand to work, skip zero
// (RULE16) skip when selected bit is clear
// (RULE17) paged table read via both pointers
// (RULE18) current page table read via low pointer
// (RULE19) last page table read via low pointer
// (RULE20) exclusive-or to work or memory, zero only
// (RULE21) untaken skip finishes in one cycle
module isa_subset_exec_unit
  import exec_unit_pkg::*;
#(
  parameter int PAGES = 4
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int PB = $clog2(PAGES);
  localparam int AW = PB + 8;

  if (PAGES < 2 || PAGES > 256 || (1 << PB) != PAGES)
  begin : g_chk
    $error("PAGES must be a power of two from 2 to 256");
  end

  // ==========================================================
  // state
  state_t state_r;
  op_t op_r;
  logic [2:0] bit_r;
  logic [7:0] operand_r, imm_r, work_register_r, mem_res_r;
  flags_t flags_r;
  logic [7:0] table_pointer_low_r, table_pointer_high_r, table_high_out_r;
  logic mem_written_r, skip_r;
  logic [1:0] cycles_r;
  logic [PB-1:0] cur_page_r;
  logic [15:0] prog_mem [PAGES*256];
  logic xfer, wr_ok, start, busy, bad;
  logic [31:0] rd_data;

  // ==========================================================
  // apb decode
  function automatic logic known_ofs(input logic [7:0] a);
    known_ofs = a == `OFS_CMD || a == `OFS_OPERAND || a == `OFS_WORK
      || a == `OFS_FLAGS || a == `OFS_TPTR || a == `OFS_RESULT
      || a == `OFS_STATUS || a == `OFS_PAGE || a == `OFS_PROG;
  endfunction
  function automatic logic read_only(input logic [7:0] a);
    read_only = a == `OFS_RESULT || a == `OFS_STATUS;
  endfunction
  assign busy = state_r != st_idle;
  assign xfer = psel & penable & pready;
  assign wr_ok = xfer & pwrite & ~pslverr;
  assign start = wr_ok & (paddr == `OFS_CMD);

  // writes refused while busy, and to read-only or unmapped words
  assign bad = ~known_ofs(paddr) | (pwrite & (busy | read_only(paddr)));

  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (paddr)
      `OFS_CMD: rd_data = {24'h00_0000, bit_r, op_r};
      `OFS_OPERAND: rd_data = {16'h0000, imm_r, operand_r};
      `OFS_WORK: rd_data = {24'h00_0000, work_register_r};
      `OFS_FLAGS: rd_data = {28'h000_0000, flags_r};
      `OFS_TPTR: rd_data = {16'h0000, table_pointer_high_r, table_pointer_low_r};
      `OFS_RESULT: rd_data = {16'h0000, table_high_out_r, mem_res_r};
      `OFS_STATUS: rd_data = {27'h000_0000, cycles_r, mem_written_r, skip_r, busy};
      `OFS_PAGE: rd_data = {24'h00_0000, 8'(cur_page_r)};
      default: rd_data = 32'h0000_0000;
    endcase
  end
  // one wait state: answer registered in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & bad;
      if (psel & penable & ~pready)
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
    end
  end

  // program word store, loaded as {address, word}
  always_ff @(posedge pclk)
  begin
    if (wr_ok && paddr == `OFS_PROG)
      prog_mem[pwdata[AW+15:16]] <= pwdata[15:0];
  end

  // ==========================================================
  // datapath
  logic [7:0] sa, sb, dec_v, inc_v, xr, work_nxt, mres_nxt;
  logic borrow_in, mwr, twr, skip_c;
  logic [8:0] diff9;
  logic [4:0] half5;
  flags_t sub_flags, flags_nxt;
  logic [AW-1:0] taddr;
  logic [15:0] tword;

  assign sa = work_register_r;
  assign sb = (op_r == subtract_immediate) ? imm_r : operand_r;
  assign borrow_in = (op_r == borrow_subtract_into_memory
    || op_r == subtract_with_borrow_to_work) ? ~flags_r.carry : 1'b0; // RULE1
  assign diff9 = {1'b0, sa} - {1'b0, sb} - {8'h00, borrow_in};
  assign half5 = {1'b0, sa[3:0]} - {1'b0, sb[3:0]} - {4'h0, borrow_in};

  always_comb
  begin
    sub_flags.carry = ~diff9[8]; // RULE2
    sub_flags.nibble_borrow_flag = ~half5[4];
    sub_flags.zero = diff9[7:0] == `ZERO_BYTE;
    sub_flags.signed_range_flag = (sa[7] ^ sb[7]) & (diff9[7] ^ sa[7]);
  end

  assign dec_v = operand_r - `ONE_BYTE;
  assign inc_v = operand_r + `ONE_BYTE;
  assign xr = work_register_r ^ ((op_r == exclusive_or_immediate) ? imm_r : operand_r);
  always_comb
  begin
    case (op_r)
      table_read_current_page: taddr = {cur_page_r, table_pointer_low_r}; // RULE18
      table_read_last_page: taddr = {{PB{1'b1}}, table_pointer_low_r}; // RULE19
      default: taddr = {table_pointer_high_r[PB-1:0], table_pointer_low_r}; // RULE17
    endcase
  end
  assign tword = prog_mem[taddr];

  always_comb
  begin
    work_nxt = work_register_r;
    flags_nxt = flags_r;
    mres_nxt = mem_res_r;
    mwr = 1'b0;
    twr = 1'b0;
    skip_c = 1'b0;
    case (op_r)
      subtract_with_borrow_to_work, subtract_to_work, subtract_immediate:
      begin
        work_nxt = diff9[7:0]; // RULE11
        flags_nxt = sub_flags;
      end
      borrow_subtract_into_memory, subtract_into_memory:
      begin
        mres_nxt = diff9[7:0]; // RULE1
        mwr = 1'b1;
        flags_nxt = sub_flags; // RULE11
      end
      decrement_skip_zero:
      begin
        mres_nxt = dec_v; // RULE3
        mwr = 1'b1;
        skip_c = dec_v == `ZERO_BYTE;
      end
      decrement_skip_zero_to_work:
      begin
        work_nxt = dec_v; // RULE4
        skip_c = dec_v == `ZERO_BYTE;
      end
      set_byte:
      begin
        mres_nxt = `ALL_ONES; // RULE6
        mwr = 1'b1;
      end
      set_bit:
      begin
        mres_nxt = operand_r | (`ONE_BYTE << bit_r); // RULE7
        mwr = 1'b1;
      end
      increment_skip_zero:
      begin
        mres_nxt = inc_v; // RULE8
        mwr = 1'b1;
        skip_c = inc_v == `ZERO_BYTE;
      end
      increment_skip_zero_to_work:
      begin
        work_nxt = inc_v; // RULE9
        skip_c = inc_v == `ZERO_BYTE;
      end
      bit_skip_if_set: skip_c = operand_r[bit_r]; // RULE10
      bit_skip_if_clear: skip_c = ~operand_r[bit_r]; // RULE16
      swap_in_place:
      begin
        mres_nxt = {operand_r[3:0], operand_r[7:4]}; // RULE12
        mwr = 1'b1;
      end
      nibble_exchange_to_work: work_nxt = {operand_r[3:0], operand_r[7:4]}; // RULE13
      skip_on_null: skip_c = operand_r == `ZERO_BYTE; // RULE14
      move_and_skip_null:
      begin
        work_nxt = operand_r; // RULE15
        skip_c = operand_r == `ZERO_BYTE;
      end
      table_read_paged, table_read_current_page, table_read_last_page:
      begin
        mres_nxt = tword[7:0]; // RULE17
        mwr = 1'b1;
        twr = 1'b1;
      end
      exclusive_or_to_work, exclusive_or_immediate:
      begin
        work_nxt = xr; // RULE20
        flags_nxt.zero = xr == `ZERO_BYTE;
      end
      exclusive_or_to_memory:
      begin
        mres_nxt = xr; // RULE20
        mwr = 1'b1;
        flags_nxt.zero = xr == `ZERO_BYTE;
      end
      default: ;
    endcase
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= st_idle;
    else
      case (state_r)
        st_idle: state_r <= start ? st_exec : st_idle;
        st_exec: state_r <= skip_c ? st_dummy : st_idle; // RULE5 RULE21
        st_dummy: state_r <= st_idle;
        default: state_r <= st_idle;
      endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      skip_r <= 1'b0;
      cycles_r <= 2'h0;
    end
    else if (state_r == st_exec)
    begin
      skip_r <= skip_c;
      cycles_r <= skip_c ? `CYC_SKIP : `CYC_PLAIN; // RULE5 RULE21
    end
  end

  // ==========================================================
  // software registers and results
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_r <= borrow_subtract_into_memory;
      bit_r <= 3'h0;
      operand_r <= `BYTE_RST;
      imm_r <= `BYTE_RST;
      table_pointer_low_r <= `BYTE_RST;
      table_pointer_high_r <= `BYTE_RST;
      cur_page_r <= '0;
    end
    else if (wr_ok)
    begin
      case (paddr)
        `OFS_CMD:
        begin
          op_r <= op_t'(pwdata[4:0]);
          bit_r <= pwdata[7:5];
        end
        `OFS_OPERAND: {imm_r, operand_r} <= pwdata[15:0];
        `OFS_TPTR: {table_pointer_high_r, table_pointer_low_r} <= pwdata[15:0];
        `OFS_PAGE: cur_page_r <= pwdata[PB-1:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      work_register_r <= `WORK_RST;
      flags_r <= `FLAGS_RST;
    end
    else if (state_r == st_exec)
    begin
      work_register_r <= work_nxt;
      flags_r <= flags_nxt;
    end
    else if (wr_ok && paddr == `OFS_WORK)
      work_register_r <= pwdata[7:0];
    else if (wr_ok && paddr == `OFS_FLAGS)
      flags_r <= pwdata[3:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_res_r <= `BYTE_RST;
      mem_written_r <= 1'b0;
      table_high_out_r <= `BYTE_RST;
    end
    else if (state_r == st_exec)
    begin
      mem_res_r <= mres_nxt;
      mem_written_r <= mwr;
      if (twr)
        table_high_out_r <= tword[15:8]; // RULE17 RULE18 RULE19
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic ex, sel_bit;
  logic [7:0] ref_borrow;
  assign ex = state_r == st_exec;
  assign sel_bit = operand_r[bit_r];
  assign ref_borrow = work_register_r - operand_r - {7'h00, ~flags_r.carry};

  skip_dummy_a: assert property (ex && skip_c |=> state_r == st_dummy ##1 state_r == st_idle) // RULE5
    else $error("taken skip lacks one dummy cycle");
  plain_single_a: assert property (ex && !skip_c |=> state_r == st_idle) // RULE21
    else $error("untaken skip not done in one cycle");
  borrow_mem_a: assert property (ex && op_r == borrow_subtract_into_memory
    |=> mem_res_r == $past(ref_borrow) && mem_written_r) // RULE1
    else $error("borrow subtract result wrong");
  sub_carry_a: assert property (ex && op_r == subtract_to_work
    |=> flags_r.carry == ($past(work_register_r) >= $past(operand_r))) // RULE2
    else $error("subtract carry wrong");
  dec_skip_a: assert property (ex && op_r == decrement_skip_zero
    |-> skip_c == (operand_r == 8'h01) ##1 flags_r == $past(flags_r)) // RULE3
    else $error("decrement skip wrong");
  inc_work_a: assert property (ex && op_r == increment_skip_zero_to_work
    |=> work_register_r == $past(operand_r) + 8'h01 && !mem_written_r) // RULE9
    else $error("increment to work wrong");
  set_byte_a: assert property (ex && op_r == set_byte
    |=> mem_res_r == 8'hff && flags_r == $past(flags_r)) // RULE6
    else $error("set byte wrong");
  bit_test_a: assert property (ex && op_r == bit_skip_if_clear
    |=> skip_r == !$past(sel_bit) && cycles_r == (!$past(sel_bit) ? 2'h2 : 2'h1)) // RULE16
    else $error("bit clear test wrong");
  swap_mem_a: assert property (ex && op_r == swap_in_place
    |=> {mem_res_r[3:0], mem_res_r[7:4]} == $past(operand_r)) // RULE12
    else $error("nibble swap wrong");
  xor_flag_a: assert property (ex && op_r == exclusive_or_to_memory
    |=> flags_r[3:1] == {$past(flags_r.signed_range_flag), $past(flags_r.nibble_borrow_flag),
      mem_res_r == 8'h00} && flags_r.carry == $past(flags_r.carry)) // RULE20
    else $error("exclusive-or flags wrong");

endmodule

// file: src/exec_unit_consts.svh
// register offsets, reset values and codes of the execution unit
// assumes byte addresses on a 32-bit apb bus, one word per register
`ifndef EXEC_UNIT_CONSTS_SVH
`define EXEC_UNIT_CONSTS_SVH
`define OFS_CMD 8'h00
`define OFS_OPERAND 8'h04
`define OFS_WORK 8'h08
`define OFS_FLAGS 8'h0c
`define OFS_TPTR 8'h10
`define OFS_RESULT 8'h14
`define OFS_STATUS 8'h18
`define OFS_PAGE 8'h1c
`define OFS_PROG 8'h20
`define WORK_RST 8'h00
`define FLAGS_RST 4'h0
`define BYTE_RST 8'h00
`define ALL_ONES 8'hff
`define ONE_BYTE 8'h01
`define ZERO_BYTE 8'h00
`define CYC_PLAIN 2'h1
`define CYC_SKIP 2'h2
`endif

// file: src/exec_unit_pkg.sv
// types shared by the execution unit
// assumes nothing beyond the constants header
package exec_unit_pkg;
  typedef enum logic [4:0] {
    borrow_subtract_into_memory = 5'h00,
    subtract_with_borrow_to_work = 5'h01,
    subtract_into_memory = 5'h02,
    subtract_to_work = 5'h03,
    subtract_immediate = 5'h04,
    decrement_skip_zero = 5'h05,
    decrement_skip_zero_to_work = 5'h06,
    set_byte = 5'h07,
    set_bit = 5'h08,
    increment_skip_zero = 5'h09,
    increment_skip_zero_to_work = 5'h0a,
    bit_skip_if_set = 5'h0b,
    swap_in_place = 5'h0c,
    nibble_exchange_to_work = 5'h0d,
    skip_on_null = 5'h0e,
    move_and_skip_null = 5'h0f,
    bit_skip_if_clear = 5'h10,
    table_read_paged = 5'h11,
    table_read_current_page = 5'h12,
    table_read_last_page = 5'h13,
    exclusive_or_to_work = 5'h14,
    exclusive_or_to_memory = 5'h15,
    exclusive_or_immediate = 5'h16
  } op_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_exec = 2'b01,
    st_dummy = 2'b10
  } state_t;
  typedef struct packed {
    logic signed_range_flag;
    logic nibble_borrow_flag;
    logic zero;
    logic carry;
  } flags_t;
endpackage

// file: sim/isa_subset_exec_unit_test.sv
// self-checking testbench of the execution unit, driven over apb
// assumes the constants header, the package and the design are compiled first
`timescale 1ns/1ns
`include "exec_unit_consts.svh"

module test_isa_subset_exec_unit
  import exec_unit_pkg::*;
;
  // =====================================================
  // signals and design
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rv;
  logic ev;
  int bad_count;
  int tests_run;

  isa_subset_exec_unit #(.PAGES(4)) u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // =====================================================
  // compare and verdict
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // =====================================================
  // apb master
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    check({31'h0, pready}, 32'h1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    check({31'h0, ev}, 32'h0);
  endtask

  task rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
    check({31'h0, ev}, 32'h0);
  endtask

  // one instruction: load operands, start, wait idle, check all results
  task run(input logic [7:0] cmd, input logic [7:0] m, input logic [7:0] imm,
           input logic [7:0] w, input logic [3:0] f, input logic [7:0] ew,
           input logic [3:0] ef, input logic [15:0] er, input logic [4:0] es);
    int n;
    wr(`OFS_OPERAND, {16'h0, imm, m});
    wr(`OFS_WORK, {24'h0, w});
    wr(`OFS_FLAGS, {28'h0, f});
    wr(`OFS_CMD, {24'h0, cmd});
    n = 0;
    do
    begin
      rd(`OFS_STATUS);
      n++;
    end
    while (rv[0] !== 1'b0 && n < 10);
    check(rv, {27'h0, es});
    rd(`OFS_WORK);
    check(rv, {24'h0, ew});
    rd(`OFS_FLAGS);
    check(rv, {28'h0, ef});
    rd(`OFS_RESULT);
    if (cmd[4:0] >= 5'h11 && cmd[4:0] <= 5'h13)
      check({16'h0, rv[15:0]}, {16'h0, er});
    else if (es[2])
      check({24'h0, rv[7:0]}, {24'h0, er[7:0]});
  endtask

  // =====================================================
  // watchdog
  initial
  begin
    #100000;
    bad_count++;
    print_verdict;
  end

  // =====================================================
  // tests
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    tests_run = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_WORK);
    check(rv, 32'h0);
    rd(`OFS_FLAGS);
    check(rv, 32'h0);
    rd(`OFS_STATUS);
    check(rv, 32'h0);
    // subtraction family
    run(8'h00, 8'h01, 8'h00, 8'h10, 4'h1, 8'h10, 4'h1, 16'h000f, 5'b01100);
    run(8'h00, 8'h05, 8'h00, 8'h05, 4'h0, 8'h05, 4'h0, 16'h00ff, 5'b01100);
    run(8'h01, 8'h00, 8'h00, 8'h00, 4'h8, 8'hff, 4'h0, 16'h0000, 5'b01000);
    run(8'h02, 8'h01, 8'h00, 8'h80, 4'h0, 8'h80, 4'h9, 16'h007f, 5'b01100);
    run(8'h03, 8'h33, 8'h00, 8'h33, 4'h0, 8'h00, 4'h7, 16'h0000, 5'b01000);
    run(8'h03, 8'hff, 8'h00, 8'h7f, 4'h1, 8'h80, 4'hc, 16'h0000, 5'b01000);
    run(8'h04, 8'h00, 8'h20, 8'h10, 4'h1, 8'hf0, 4'h4, 16'h0000, 5'b01000);
    // decrement and increment with skip
    run(8'h05, 8'h01, 8'h00, 8'h55, 4'ha, 8'h55, 4'ha, 16'h0000, 5'b10110);
    run(8'h05, 8'h00, 8'h00, 8'h55, 4'h5, 8'h55, 4'h5, 16'h00ff, 5'b01100);
    run(8'h06, 8'h01, 8'h00, 8'h33, 4'hf, 8'h00, 4'hf, 16'h0000, 5'b10010);
    run(8'h06, 8'h10, 8'h00, 8'h00, 4'h0, 8'h0f, 4'h0, 16'h0000, 5'b01000);
    run(8'h09, 8'hff, 8'h00, 8'h11, 4'h6, 8'h11, 4'h6, 16'h0000, 5'b10110);
    run(8'h09, 8'h7f, 8'h00, 8'h11, 4'h9, 8'h11, 4'h9, 16'h0080, 5'b01100);
    run(8'h0a, 8'hff, 8'h00, 8'h22, 4'h3, 8'h00, 4'h3, 16'h0000, 5'b10010);
    // set byte, set bit, swaps
    run(8'h07, 8'h12, 8'h00, 8'h44, 4'h5, 8'h44, 4'h5, 16'h00ff, 5'b01100);
    run(8'h68, 8'h00, 8'h00, 8'h44, 4'ha, 8'h44, 4'ha, 16'h0008, 5'b01100);
    run(8'he8, 8'h7f, 8'h00, 8'h44, 4'h0, 8'h44, 4'h0, 16'h00ff, 5'b01100);
    run(8'h0c, 8'h3c, 8'h00, 8'h66, 4'hf, 8'h66, 4'hf, 16'h00c3, 5'b01100);
    run(8'h0d, 8'ha5, 8'h00, 8'h00, 4'h3, 8'h5a, 4'h3, 16'h0000, 5'b01000);
    // tests that skip
    run(8'hab, 8'h20, 8'h00, 8'h77, 4'h6, 8'h77, 4'h6, 16'h0000, 5'b10010);
    run(8'hab, 8'hdf, 8'h00, 8'h77, 4'h6, 8'h77, 4'h6, 16'h0000, 5'b01000);
    run(8'h0e, 8'h00, 8'h00, 8'h88, 4'h9, 8'h88, 4'h9, 16'h0000, 5'b10010);
    run(8'h0e, 8'h01, 8'h00, 8'h88, 4'h9, 8'h88, 4'h9, 16'h0000, 5'b01000);
    run(8'h0f, 8'h00, 8'h00, 8'h99, 4'h5, 8'h00, 4'h5, 16'h0000, 5'b10010);
    run(8'h0f, 8'h9c, 8'h00, 8'h00, 4'h5, 8'h9c, 4'h5, 16'h0000, 5'b01000);
    run(8'hd0, 8'hbf, 8'h00, 8'haa, 4'hc, 8'haa, 4'hc, 16'h0000, 5'b10010);
    run(8'hd0, 8'h40, 8'h00, 8'haa, 4'hc, 8'haa, 4'hc, 16'h0000, 5'b01000);
    // exclusive-or forms
    run(8'h14, 8'h0f, 8'h00, 8'hf0, 4'hf, 8'hff, 4'hd, 16'h0000, 5'b01000);
    run(8'h15, 8'h5a, 8'h00, 8'h5a, 4'h0, 8'h5a, 4'h2, 16'h0000, 5'b01100);
    run(8'h16, 8'h00, 8'h01, 8'h01, 4'h0, 8'h00, 4'h2, 16'h0000, 5'b01000);
    // table reads from three pages
    wr(`OFS_PROG, {6'h0, 10'h234, 16'hbeef});
    wr(`OFS_PROG, {6'h0, 10'h134, 16'h1357});
    wr(`OFS_PROG, {6'h0, 10'h334, 16'ha5c3});
    wr(`OFS_TPTR, 32'h0000_0234);
    wr(`OFS_PAGE, 32'h0000_0001);
    run(8'h11, 8'h00, 8'h00, 8'h55, 4'h6, 8'h55, 4'h6, 16'hbeef, 5'b01100);
    run(8'h12, 8'h00, 8'h00, 8'h55, 4'h6, 8'h55, 4'h6, 16'h1357, 5'b01100);
    run(8'h13, 8'h00, 8'h00, 8'h55, 4'h9, 8'h55, 4'h9, 16'ha5c3, 5'b01100);
    // refused writes
    xfer(1'b1, 8'h40, 32'h1);
    check({31'h0, ev}, 32'h1);
    xfer(1'b1, `OFS_RESULT, 32'h0);
    check({31'h0, ev}, 32'h1);
    print_verdict;
  end
endmodule
